// ---- hdl/ltr_pkg.sv ----
// Summary of operation
// - Conversion result register, host read only
// - Result code step is 30 mV
// - Three engine variables, read only, reset zero
// - Only own engine updates its variable
// - Group dimmers read-write, reset zero
// - One dimmer write dims whole group
// - Triggered conversion lasts 2.7 ms
// - Third dimmer follows at next address
`default_nettype none
package ltr_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] LTR_OFS_RESULT = 8'h42;
  localparam logic [7:0] LTR_OFS_VAR1 = 8'h45;
  localparam logic [7:0] LTR_OFS_VAR2 = 8'h46;
  localparam logic [7:0] LTR_OFS_VAR3 = 8'h47;
  localparam logic [7:0] LTR_OFS_DIM1 = 8'h48;
  localparam logic [7:0] LTR_OFS_DIM2 = 8'h49;
  localparam logic [7:0] LTR_OFS_DIM3 = 8'h4A;
  // ==========================================================
  // Reset values and scaling
  localparam logic [7:0] LTR_RST_ZERO = 8'h00;
  localparam int LTR_CODE_STEP_MV = 30;
  localparam int LTR_CODE_OFFSET_MV = 1478;
  localparam logic [7:0] LTR_DIM_FULL = 8'hFF;
  // ==========================================================
  // Timing
  localparam int LTR_CLK_HZ = 20000000;
  localparam int LTR_CONV_TIME_US = 2700;
  localparam int LTR_CONV_CYCLES = LTR_CLK_HZ / 1000 * LTR_CONV_TIME_US / 1000;
endpackage
`default_nettype wire

// ---- hdl/ltr_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
// Register slice: test result, engine variables, group dimmers
module ltr_regs #(
  parameter int CONV_CYCLES = ltr_pkg::LTR_CONV_CYCLES,
  parameter int N_LED = 9
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  // Host register port: one-cycle strobes with address
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  input wire logic host_rd,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  // Conversion trigger and converter sample
  input wire logic led_check_trigger,
  input wire logic [7:0] adc_sample,
  output logic conv_busy,
  // Engine variable write paths
  input wire logic [2:0] eng_var_we,
  input wire logic [23:0] eng_var_wdata,
  // Per-LED duty and group mapping (2 bits each: 0 none, 1..3 group)
  input wire logic [N_LED*8-1:0] led_pwm,
  input wire logic [N_LED*2-1:0] led_group,
  output logic [N_LED*8-1:0] led_duty,
  output logic [23:0] group_dimmer_out
);
  // ==========================================================
  // Elaboration checks
  if (CONV_CYCLES < 1) begin : g_bad_conv
    $error("CONV_CYCLES must be at least one");
  end
  if (N_LED < 1) begin : g_bad_led
    $error("N_LED must be at least one");
  end

  // ==========================================================
  // Reset synchroniser
  logic rst_s1_reg;
  logic rst_n_reg;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  // ==========================================================
  // Conversion timer
  logic [31:0] conv_cnt_reg;
  logic [31:0] conv_cnt_next;
  logic [7:0] result_reg;
  logic conv_done;
  logic conv_start;
  // A trigger during a conversion is ignored, the running one finishes
  assign conv_start = led_check_trigger && (conv_cnt_reg == 32'h0);
  assign conv_done = (conv_cnt_reg == 32'h1);
  assign conv_cnt_next = conv_start ? 32'(CONV_CYCLES) :
                         (conv_cnt_reg != 32'h0) ? conv_cnt_reg - 32'h1 :
                         32'h0;
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      conv_cnt_reg <= 32'h0;
      conv_busy <= 1'b0;
    end else begin
      conv_cnt_reg <= conv_cnt_next;
      conv_busy <= (conv_cnt_next != 32'h0);
    end
  end

  // Result captured only at conversion end; host writes never reach it
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      result_reg <= ltr_pkg::LTR_RST_ZERO;
    end else if (conv_done) begin
      result_reg <= adc_sample;
    end
  end

  // ==========================================================
  // Engine variables and group dimmers
  logic [7:0] var_reg [3];
  logic [7:0] dim_reg [3];
  logic [7:0] var_ofs [3];
  logic [7:0] dim_ofs [3];
  assign var_ofs[0] = ltr_pkg::LTR_OFS_VAR1;
  assign var_ofs[1] = ltr_pkg::LTR_OFS_VAR2;
  assign var_ofs[2] = ltr_pkg::LTR_OFS_VAR3;
  assign dim_ofs[0] = ltr_pkg::LTR_OFS_DIM1;
  assign dim_ofs[1] = ltr_pkg::LTR_OFS_DIM2;
  assign dim_ofs[2] = ltr_pkg::LTR_OFS_DIM3;

  for (genvar g = 0; g < 3; g++) begin : g_grp
    // Variables ignore the host; only the owning engine writes
    always_ff @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
        var_reg[g] <= ltr_pkg::LTR_RST_ZERO;
      end else if (eng_var_we[g]) begin
        var_reg[g] <= eng_var_wdata[g*8 +: 8];
      end
    end
    always_ff @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
        dim_reg[g] <= ltr_pkg::LTR_RST_ZERO;
      end else if (host_wr && host_addr == dim_ofs[g]) begin
        dim_reg[g] <= host_wdata;
      end
    end
    always_ff @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
        group_dimmer_out[g*8 +: 8] <= ltr_pkg::LTR_RST_ZERO;
      end else begin
        group_dimmer_out[g*8 +: 8] <= dim_reg[g];
      end
    end
  end

  // ==========================================================
  // Per-LED scaling; one dimmer value reaches every mapped LED
  for (genvar i = 0; i < N_LED; i++) begin : g_led
    logic [1:0] grp;
    logic [7:0] fade;
    logic [15:0] prod;
    logic [7:0] scaled;
    logic [15:0] biased;
    assign grp = led_group[i*2 +: 2];
    assign fade = (grp == 2'h1) ? dim_reg[0] :
                  (grp == 2'h2) ? dim_reg[1] :
                  (grp == 2'h3) ? dim_reg[2] : ltr_pkg::LTR_DIM_FULL;
    assign prod = led_pwm[i*8 +: 8] * fade;
    // Divide by 255 rounded to nearest: bias by half, then fold the
    // high byte of the biased value back in; exact for any 8x8 product,
    // so a full dimmer leaves the duty untouched
    assign biased = prod + 16'h0080;
    assign scaled = 8'((biased + (biased >> 8)) >> 8);
    always_ff @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
        led_duty[i*8 +: 8] <= 8'h00;
      end else begin
        led_duty[i*8 +: 8] <= (grp == 2'h0) ? led_pwm[i*8 +: 8] : scaled;
      end
    end
  end

  // ==========================================================
  // Read decode; unmapped offsets read zero
  logic [7:0] rd_mux;
  assign rd_mux =
    (host_addr == ltr_pkg::LTR_OFS_RESULT) ? result_reg :
    (host_addr == var_ofs[0]) ? var_reg[0] :
    (host_addr == var_ofs[1]) ? var_reg[1] :
    (host_addr == var_ofs[2]) ? var_reg[2] :
    (host_addr == dim_ofs[0]) ? dim_reg[0] :
    (host_addr == dim_ofs[1]) ? dim_reg[1] :
    (host_addr == dim_ofs[2]) ? dim_reg[2] : 8'h00;
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      host_rdata <= 8'h00;
      host_rvalid <= 1'b0;
    end else begin
      host_rdata <= host_rd ? rd_mux : host_rdata;
      host_rvalid <= host_rd;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_reg);

  result_ro_a: assert property (
    !conv_done |=> $stable(result_reg))
    else $error("result changed outside conversion end");
  conv_len_a: assert property (
    conv_start |=> conv_busy ##0 (conv_cnt_reg == 32'(CONV_CYCLES)))
    else $error("conversion did not start with full count");
  conv_cap_a: assert property (
    conv_done |=> (result_reg == $past(adc_sample)) && !conv_busy)
    else $error("result not captured at conversion end");
  var_own_a: assert property (
    !eng_var_we[0] |=> $stable(var_reg[0]))
    else $error("engine variable changed without its engine");
  var_load_a: assert property (
    eng_var_we[1] |=> var_reg[1] == $past(eng_var_wdata[15:8]))
    else $error("engine variable not loaded");
  dim_wr_a: assert property (
    host_wr && host_addr == ltr_pkg::LTR_OFS_DIM1
    |=> dim_reg[0] == $past(host_wdata))
    else $error("dimmer write lost");
  dim3_wr_a: assert property (
    host_wr && host_addr == ltr_pkg::LTR_OFS_DIM3
    |=> ##1 group_dimmer_out[23:16] == $past(host_wdata, 2))
    else $error("third dimmer write lost");
  read_res_a: assert property (
    host_rd && host_addr == ltr_pkg::LTR_OFS_RESULT
    |=> host_rvalid && host_rdata == $past(result_reg))
    else $error("result read wrong");
  duty_full_a: assert property (
    led_group[5:4] == 2'h2 && dim_reg[1] == 8'hFF
    |=> led_duty[23:16] == $past(led_pwm[23:16]))
    else $error("full dimmer altered duty");
  duty_zero_a: assert property (
    led_group[3:2] == 2'h1 && dim_reg[0] == 8'h00
    |=> led_duty[15:8] == 8'h00)
    else $error("zero dimmer left duty on");

  // Read port answers every strobe once; data holds between reads
  read_valid_a: assert property (
    host_rd |=> host_rvalid)
    else $error("read strobe not answered");
  rdata_hold_a: assert property (
    !host_rd |=> $stable(host_rdata) && !host_rvalid)
    else $error("read data moved without a read");
  dim_out_a: assert property (
    1'b1 |=> group_dimmer_out[15:8] == $past(dim_reg[1]))
    else $error("dimmer output copy lags");

  conv_cov_c: cover property (conv_done ##1 !conv_busy);
  dim_cov_c: cover property (host_wr && host_addr == dim_ofs[2]);
  var_cov_c: cover property (eng_var_we[2] ##1 host_rd);
  rd_cov_c: cover property (host_rd && host_addr == var_ofs[0]);
endmodule
`default_nettype wire

// ---- testbench/ltr_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// Host model of the register port, driving after falling edges
module ltr_host (
  input wire logic ref_clk,
  output logic [7:0] host_addr,
  output logic host_wr,
  output logic [7:0] host_wdata,
  output logic host_rd,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid
);
  initial begin
    host_addr = 8'h00;
    host_wr = 1'b0;
    host_wdata = 8'h00;
    host_rd = 1'b0;
  end
  // Spare cycle after a write so the strobe is never set twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge ref_clk);
    host_wr = 1'b0;
    host_wdata = ~d; // Released data must not look valid
    @(negedge ref_clk);
  endtask
  // Answer stands for the one cycle after the strobe; taken inside it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge ref_clk);
    d = host_rvalid ? host_rdata : 8'hEE;
    host_rd = 1'b0;
    host_addr = ~a;
    @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

// ---- testbench/test_led_test_result_engine_vars_faders.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  error_cnt++; $display("mismatch %0t got %h exp %h", $time, a, b); end end
module test_led_test_result_engine_vars_faders;
  logic ref_clk, arst_n, trig, busy, wr, rd, rv;
  logic [7:0] addr, wdata, rdata, adc, d;
  logic [2:0] we;
  logic [23:0] evd, gout;
  logic [71:0] pwm, duty;
  logic [17:0] grp;
  logic [7:0] dv [3];
  int error_cnt = 0;
  int check_count = 0;
  ltr_regs #(.CONV_CYCLES(10), .N_LED(9)) dut (.ref_clk(ref_clk),
    .arst_n(arst_n), .host_addr(addr), .host_wr(wr), .host_wdata(wdata),
    .host_rd(rd), .host_rdata(rdata), .host_rvalid(rv),
    .led_check_trigger(trig), .adc_sample(adc), .conv_busy(busy),
    .eng_var_we(we), .eng_var_wdata(evd), .led_pwm(pwm), .led_group(grp),
    .led_duty(duty), .group_dimmer_out(gout));
  ltr_host host (.ref_clk(ref_clk), .host_addr(addr), .host_wr(wr),
    .host_wdata(wdata), .host_rd(rd), .host_rdata(rdata), .host_rvalid(rv));
  // ==========
  // Clock, watchdog and verdict
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Outputs two cycles after the last dimmer write; rounding to nearest
  task automatic chk_out();
    logic [1:0] g;
    logic [7:0] e;
    repeat (2) @(negedge ref_clk);
    `CHK(gout, {dv[2], dv[1], dv[0]})
    for (int i = 0; i < 9; i++) begin
      g = grp[i*2+:2];
      e = pwm[i*8+:8];
      if (g != 2'h0) e = 8'((32'(e) * 32'(dv[g-2'h1]) + 127) / 255);
      `CHK(duty[i*8+:8], e)
    end
  endtask
  // ==========
  // Main sequence
  initial begin
    arst_n = 1'b0;
    trig = 1'b0;
    adc = 8'((3502 + 1478) / 30);
    we = 3'h0;
    evd = 24'h3CA517;
    pwm = 72'hC8_80_40_FF_10_7F_C8_80_FE;
    grp = 18'h1E4E4;
    repeat (5) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    // Reset values, gaps 0x43/0x44 read as zero
    for (int a = 8'h42; a <= 8'h4A; a++) begin
      host.rd(8'(a), d);
      `CHK(d, 8'h00)
    end
    // Read-only places ignore host writes
    host.wr(8'h42, 8'h5A);
    host.wr(8'h46, 8'h5A);
    host.rd(8'h42, d);
    `CHK(d, 8'h00)
    host.rd(8'h46, d);
    `CHK(d, 8'h00)
    // Dimmers including the third one
    dv = '{8'h80, 8'hFF, 8'h33};
    for (int i = 0; i < 3; i++) host.wr(8'h48 + 8'(i), dv[i]);
    for (int i = 0; i < 3; i++) begin
      host.rd(8'h48 + 8'(i), d);
      `CHK(d, dv[i])
    end
    chk_out();
    dv[0] = 8'h00;
    host.wr(8'h48, 8'h00);
    chk_out();
    // Engines 1 and 3 write; engine 2 must keep zero
    we = 3'b101;
    @(negedge ref_clk);
    we = 3'b000;
    for (int i = 0; i < 3; i++) begin
      host.rd(8'h45 + 8'(i), d);
      `CHK(d, i == 1 ? 8'h00 : evd[i*8+:8])
    end
    // Conversion with a refused retrigger while busy
    trig = 1'b1;
    @(negedge ref_clk);
    trig = 1'b0;
    `CHK(busy, 1'b1)
    @(negedge ref_clk);
    trig = 1'b1;
    @(negedge ref_clk);
    trig = 1'b0;
    repeat (7) @(negedge ref_clk);
    `CHK(busy, 1'b1)
    @(negedge ref_clk);
    `CHK(busy, 1'b0)
    host.rd(8'h42, d);
    `CHK(d, 8'hA6)
    end_of_test();
  end
endmodule
`default_nettype wire
